// [logic/bdcm_cfg.svh]
/*
  Constants of the bus and digital command merge block: register offsets,
  field positions, reset values and timing counts.
  Assumes it is included by bare name from the top and watchdog design files.
*/
`ifndef BDCM_CFG_SVH
`define BDCM_CFG_SVH

// Register byte offsets
`define BDCM_OFS_MODE      12'h000
`define BDCM_OFS_PROFILE   12'h004
`define BDCM_OFS_JOG_ONE   12'h008
`define BDCM_OFS_JOG_TWO   12'h00C
`define BDCM_OFS_TIMEOUT   12'h010
`define BDCM_OFS_LOSSACT   12'h014
`define BDCM_OFS_FMAX      12'h018
`define BDCM_OFS_STATUS    12'h01C
`define BDCM_OFS_IRQ_STAT  12'h020
`define BDCM_OFS_IRQ_MASK  12'h024

// Mode register fields (reversing, setup, preset)
`define BDCM_MODE_REV_LSB  0
`define BDCM_MODE_SET_LSB  2
`define BDCM_MODE_PRE_LSB  4

// Reset values
`define BDCM_MODE_RESET    2'h3
`define BDCM_PROFILE_RESET 2'h0
`define BDCM_PROFILE_MAX   2'h2
`define BDCM_PROFILE_NATIVE 2'h1
`define BDCM_PROFILE_STDPRO 2'h0
`define BDCM_JOG_RESET     16'h0064
`define BDCM_FMAX_RESET    16'h0FA0
`define BDCM_TIMEOUT_RESET 7'h01
`define BDCM_TIMEOUT_MIN   7'h01
`define BDCM_TIMEOUT_MAX   7'h63
`define BDCM_LOSSACT_RESET 3'h0
`define BDCM_LOSSACT_MAX   3'h5

// Timing: core clock in Hz, one second in cycles
`define BDCM_CLK_HZ        25000000
`define BDCM_SEC_CYCLES    (`BDCM_CLK_HZ * 1)

// Interrupt bits
`define BDCM_IRQ_LOST      0
`define BDCM_IRQ_BACK      1

`endif

// [logic/bdcm_merge.sv]
/*
  Four-way source merge of one command field, digital versus serial.
  Assumes a mode code from bdcm_pkg; purely combinational.
*/
`timescale 1ns/1ns
`default_nettype none
module bdcm_merge #(
  parameter int W = 1
) (
  // Mode and sources
  input  wire bdcm_pkg::bdcm_src_t mode_in,
  input  wire logic [W-1:0]        dig_in,
  input  wire logic [W-1:0]        ser_in,
  // Merged result
  output logic [W-1:0]             merged_out
);
  // Bitwise selection by mode
  always_comb begin
    case (mode_in)
      bdcm_pkg::BDCM_SRC_DIG: merged_out = dig_in;
      bdcm_pkg::BDCM_SRC_SER: merged_out = ser_in;
      bdcm_pkg::BDCM_SRC_AND: merged_out = dig_in & ser_in;
      default:                merged_out = dig_in | ser_in;
    endcase
  end
endmodule // bdcm_merge
`default_nettype wire

// [logic/bdcm_pkg.sv]
/*
  Types of the bus and digital command merge block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bdcm_pkg;
  // Source mode of a merged command
  typedef enum logic [1:0] {
    BDCM_SRC_DIG = 2'h0,
    BDCM_SRC_SER = 2'h1,
    BDCM_SRC_AND = 2'h2,
    BDCM_SRC_OR  = 2'h3
  } bdcm_src_t;

  // Bus-loss reaction codes
  typedef enum logic [2:0] {
    BDCM_LOSS_OFF    = 3'h0,
    BDCM_LOSS_FREEZE = 3'h1,
    BDCM_LOSS_STOP   = 3'h2,
    BDCM_LOSS_JOG    = 3'h3,
    BDCM_LOSS_FMAX   = 3'h4,
    BDCM_LOSS_TRIP   = 3'h5
  } bdcm_loss_t;

  // Link watchdog states, Gray along the usual path
  typedef enum logic [1:0] {
    BDCM_WD_IDLE = 2'h0,
    BDCM_WD_OK   = 2'h1,
    BDCM_WD_LOST = 2'h3
  } bdcm_wd_t;
endpackage

// [logic/bdcm_top.sv]
/*
  Bus and digital command merge: reversing, setup and preset selection
  from terminals and fieldbus, jog speeds, profile and link watchdog,
  with an APB register file and one level interrupt.
  Assumes terminal and fieldbus inputs are synchronous to core_clk_in.
*/
//
// Behaviour
// - reversing merged per four-way mode
// - setup code plus one, merged per four-way mode
// - preset selection merged per four-way mode; outside native profile logic AND falls back to the terminals
// - serial presets only in native profile
// - serial jog select only in profile zero
// - jog speeds limited to fmax, default 10Hz
// - profile setting holds codes zero to two
// - timeout 1 to 99 seconds, default one
// - gap overrun marks link lost, reaction applies
// - loss reaction codes, relay released 1-5
`timescale 1ns/1ns
`default_nettype none
`include "bdcm_cfg.svh"
module bdcm_top #(
  parameter int SEC_CYCLES = `BDCM_SEC_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Digital terminals
  input  wire logic        dig_rev_in,
  input  wire logic [1:0]  dig_setup_in,
  input  wire logic [1:0]  dig_preset_in,
  // Fieldbus decoded control word
  input  wire logic        tele_ok_in,
  input  wire logic        ser_rev_in,
  input  wire logic [1:0]  ser_setup_in,
  input  wire logic [1:0]  ser_preset_in,
  input  wire logic        ser_jog_one_in,
  input  wire logic        ser_jog_two_in,
  // Merged commands
  output logic             reverse_out,
  output logic [2:0]       setup_num_out,
  output logic [1:0]       preset_sel_out,
  output logic             jog_active_out,
  output logic [15:0]      jog_freq_out,
  output logic [1:0]       profile_out,
  // Bus-loss reaction
  output logic             bus_lost_out,
  output logic [2:0]       loss_action_out,
  output logic             relay_release_out,
  // Interrupt
  output logic             irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // Every configuration field resets to its default, so the drive
  // behaves sanely before software has written anything.
  logic [5:0]  mode_reg;      // Source modes: reverse, setup, preset
  logic [1:0]  profile_reg;   // Control word profile
  logic [15:0] jog_one_reg;   // Fixed bus speed one, 0.1 Hz units
  logic [15:0] jog_two_reg;   // Fixed bus speed two, 0.1 Hz units
  logic [15:0] fmax_reg;      // Top output frequency limit
  logic [6:0]  timeout_reg;   // Bus timeout in seconds
  logic [2:0]  lossact_reg;   // Bus-loss reaction code
  logic [1:0]  irq_stat_reg;  // Sticky events
  logic [1:0]  irq_mask_reg;  // Interrupt enables
  logic        lost_prev_reg; // Lost level one cycle ago
  logic        lost_w;        // Watchdog lost level

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  // Decode compares the full 12-bit byte address, so an unaligned or
  // unmapped address never aliases onto a register; it gets the error
  // answer instead.
  wire        wr_en  = psel_in && penable_in && pwrite_in;
  wire        rd_en  = psel_in && penable_in && !pwrite_in;
  wire        hit_mode  = (paddr_in == `BDCM_OFS_MODE);
  wire        hit_prof  = (paddr_in == `BDCM_OFS_PROFILE);
  wire        hit_jog1  = (paddr_in == `BDCM_OFS_JOG_ONE);
  wire        hit_jog2  = (paddr_in == `BDCM_OFS_JOG_TWO);
  wire        hit_tmo   = (paddr_in == `BDCM_OFS_TIMEOUT);
  wire        hit_loss  = (paddr_in == `BDCM_OFS_LOSSACT);
  wire        hit_fmax  = (paddr_in == `BDCM_OFS_FMAX);
  wire        hit_stat  = (paddr_in == `BDCM_OFS_STATUS);
  wire        hit_istat = (paddr_in == `BDCM_OFS_IRQ_STAT);
  wire        hit_imask = (paddr_in == `BDCM_OFS_IRQ_MASK);
  wire        mapped = hit_mode | hit_prof | hit_jog1 | hit_jog2 | hit_tmo |
                       hit_loss | hit_fmax | hit_stat | hit_istat | hit_imask;

  // Clamp a speed to the top frequency limit
  // Shared by the write path and the output path, so both clamp alike
  function automatic logic [15:0] clamp_speed(input logic [15:0] v, input logic [15:0] lim);
    clamp_speed = (v > lim) ? lim : v;
  endfunction

  // Value checks: a refused write answers with an error and stores
  // nothing, so a bad value never reaches the command path.
  // profile codes above two are refused
  wire        prof_ok = (pwdata_in[1:0] <= `BDCM_PROFILE_MAX);
  wire        tmo_ok  = (pwdata_in[6:0] >= `BDCM_TIMEOUT_MIN) &&
                        (pwdata_in[6:0] <= `BDCM_TIMEOUT_MAX) && (pwdata_in[31:7] == 25'h0);
  // loss reaction codes zero to five
  wire        loss_ok = (pwdata_in[2:0] <= `BDCM_LOSSACT_MAX);
  wire        bad_val = (hit_prof && !prof_ok) || (hit_tmo && !tmo_ok) ||
                        (hit_loss && !loss_ok);
  wire        slv_err = !mapped || (pwrite_in && bad_val);

  ////////////////////////////////////////////////////////////////////////////
  // Command merges
  // Merges are pure selection; the results are registered together
  // further down, so every command moves on the same edge.
  // Reverse and setup modes are read straight from the mode register; the preset mode is gated first.
  wire        rev_m;
  wire [1:0]  setup_m;
  wire [1:0]  preset_m;

  bdcm_merge #(.W(1)) u_rev (
    .mode_in    (bdcm_pkg::bdcm_src_t'(mode_reg[`BDCM_MODE_REV_LSB +: 2])),
    .dig_in     (dig_rev_in),
    .ser_in     (ser_rev_in),
    .merged_out (rev_m)
  );

  // setup merged bitwise under its mode
  bdcm_merge #(.W(2)) u_setup (
    .mode_in    (bdcm_pkg::bdcm_src_t'(mode_reg[`BDCM_MODE_SET_LSB +: 2])),
    .dig_in     (dig_setup_in),
    .ser_in     (ser_setup_in),
    .merged_out (setup_m)
  );

  // serial presets gated by native profile
  wire        pre_ser_ok = (profile_reg == `BDCM_PROFILE_NATIVE);
  wire [1:0]  ser_pre_g  = pre_ser_ok ? ser_preset_in : 2'h0;
  wire [1:0]  pre_mode   = mode_reg[`BDCM_MODE_PRE_LSB +: 2];
  // Outside the native profile serial presets add nothing to the merge;
  // logic AND would then force zero, so it falls back to the terminals
  wire [1:0]  pre_mode_g = (!pre_ser_ok && pre_mode == bdcm_pkg::BDCM_SRC_AND) ?
                           bdcm_pkg::BDCM_SRC_DIG : pre_mode;

  bdcm_merge #(.W(2)) u_pre (
    .mode_in    (bdcm_pkg::bdcm_src_t'(pre_mode_g)),
    .dig_in     (dig_preset_in),
    .ser_in     (ser_pre_g),
    .merged_out (preset_m)
  );

  // jog select in profile zero only
  wire        jog_prof = (profile_reg == `BDCM_PROFILE_STDPRO);
  // Jog one wins when the master sets both select bits
  wire        jog_sel  = jog_prof && (ser_jog_one_in || ser_jog_two_in);
  wire [15:0] jog_val  = ser_jog_one_in ? jog_one_reg : jog_two_reg;

  // relay released for reactions one to five
  // Only a lost link drives the relay; reaction off keeps it held
  wire        relay_rel = lost_w && (lossact_reg != bdcm_pkg::BDCM_LOSS_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  // Armed only after the first telegram, so a drive run from the
  // terminals alone never reports a lost link. A telegram that comes
  // in while lost brings the link back at once.
  // gap overrun declares link lost
  bdcm_watchdog #(.SEC_CYCLES(SEC_CYCLES)) u_wd (
    .core_clk_in  (core_clk_in),
    .reset_n_in   (reset_n_in),
    .tele_ok_in   (tele_ok_in),
    .timeout_s_in (timeout_reg),
    .lost_out     (lost_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  // Status bits are live levels; only the interrupt status is sticky.
  // Unmapped addresses read as zero.
  wire [31:0] rd_data =
      hit_mode  ? {26'h0, mode_reg}              :
      hit_prof  ? {30'h0, profile_reg}           :
      hit_jog1  ? {16'h0, jog_one_reg}           :
      hit_jog2  ? {16'h0, jog_two_reg}           :
      hit_tmo   ? {25'h0, timeout_reg}           :
      hit_loss  ? {29'h0, lossact_reg}           :
      hit_fmax  ? {16'h0, fmax_reg}              :
      hit_stat  ? {29'h0, relay_rel, lost_w, tele_ok_in} :
      hit_istat ? {30'h0, irq_stat_reg}          :
      hit_imask ? {30'h0, irq_mask_reg}          : 32'h00000000;

  // Interrupt events: link lost and link regained
  wire [1:0]  irq_evt = {(!lost_w && lost_prev_reg), (lost_w && !lost_prev_reg)};
  // Set wins over write-one-clear
  wire [1:0]  irq_clr = (wr_en && hit_istat) ? pwdata_in[1:0] : 2'h0;
  wire [1:0]  irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_evt;

  ////////////////////////////////////////////////////////////////////////////
  // APB answer, zero wait: pready high in every access phase
  // The answer is formed at the setup edge, while address, direction
  // and data already stand, so the access phase never waits.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
    end else begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && slv_err;
      prdata_out  <= (psel_in && !penable_in && !pwrite_in) ? rd_data : 32'h00000000;
    end
  end

  // Register writes land on the access edge with pready high
  wire        wr_take = wr_en && pready_out && !slv_err;

  // Configuration registers
  // A write clamps jog speeds to the limit in force at that moment; a
  // later, lower limit is still honoured by the output clamp.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      // all source modes default to logic OR
      mode_reg     <= {`BDCM_MODE_RESET, `BDCM_MODE_RESET, `BDCM_MODE_RESET};
      profile_reg  <= `BDCM_PROFILE_RESET;
      jog_one_reg  <= `BDCM_JOG_RESET;
      jog_two_reg  <= `BDCM_JOG_RESET;
      fmax_reg     <= `BDCM_FMAX_RESET;
      timeout_reg  <= `BDCM_TIMEOUT_RESET;
      lossact_reg  <= `BDCM_LOSSACT_RESET;
      irq_mask_reg <= 2'h0;
    end else if (wr_take) begin
      if (hit_mode)  mode_reg     <= pwdata_in[5:0];
      if (hit_prof)  profile_reg  <= pwdata_in[1:0];
      if (hit_jog1)  jog_one_reg  <= clamp_speed(pwdata_in[15:0], fmax_reg);
      if (hit_jog2)  jog_two_reg  <= clamp_speed(pwdata_in[15:0], fmax_reg);
      if (hit_fmax)  fmax_reg     <= pwdata_in[15:0];
      if (hit_tmo)   timeout_reg  <= pwdata_in[6:0];
      if (hit_loss)  lossact_reg  <= pwdata_in[2:0];
      if (hit_imask) irq_mask_reg <= pwdata_in[1:0];
    end
  end

  // Interrupt status and output
  // The output follows the next status, so it rises with the event flag
  // and drops in the cycle in which a write-one-clear lands.
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      irq_stat_reg  <= 2'h0;
      lost_prev_reg <= 1'b0;
      irq_out       <= 1'b0;
    end else begin
      irq_stat_reg  <= irq_stat_next;
      lost_prev_reg <= lost_w;
      irq_out       <= |(irq_stat_next & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every command leaves through a flip-flop, one edge after the inputs
  // it was merged from; reset means clockwise, setup 1, no jog.
  // merged outputs registered
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      reverse_out       <= 1'b0;
      setup_num_out     <= 3'h1;
      preset_sel_out    <= 2'h0;
      jog_active_out    <= 1'b0;
      jog_freq_out      <= 16'h0000;
      profile_out       <= `BDCM_PROFILE_RESET;
      bus_lost_out      <= 1'b0;
      loss_action_out   <= `BDCM_LOSSACT_RESET;
      relay_release_out <= 1'b0;
    end else begin
      reverse_out       <= rev_m;
      // setup number is code plus one
      setup_num_out     <= {1'b0, setup_m} + 3'h1;
      preset_sel_out    <= preset_m;
      jog_active_out    <= jog_sel;
      jog_freq_out      <= jog_sel ? clamp_speed(jog_val, fmax_reg) : 16'h0000;
      profile_out       <= profile_reg;
      bus_lost_out      <= lost_w;
      loss_action_out   <= lost_w ? lossact_reg : `BDCM_LOSSACT_RESET;
      relay_release_out <= relay_rel;
    end
  end
endmodule // bdcm_top
`default_nettype wire

// [logic/bdcm_watchdog.sv]
/*
  Telegram gap watchdog: counts seconds since the last good telegram.
  Assumes a one-cycle telegram strobe and a timeout of 1 to 99 seconds.
*/
`timescale 1ns/1ns
`default_nettype none
`include "bdcm_cfg.svh"
module bdcm_watchdog #(
  parameter int SEC_CYCLES = `BDCM_SEC_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  // Telegram strobe and limit
  input  wire logic       tele_ok_in,
  input  wire logic [6:0] timeout_s_in,
  // Link state
  output logic            lost_out
);
  logic [24:0]        tick_reg;   // Cycles within one second
  logic [6:0]         sec_reg;    // Whole seconds elapsed
  bdcm_pkg::bdcm_wd_t state_reg;  // Watchdog state
  bdcm_pkg::bdcm_wd_t state_next;
  wire                sec_end  = (tick_reg == 25'(SEC_CYCLES - 1));
  wire                expired  = sec_end && ((sec_reg + 7'h01) >= timeout_s_in);

  // Next state: idle until first telegram, lost on gap overrun
  always_comb begin
    case (state_reg)
      bdcm_pkg::BDCM_WD_IDLE: state_next = tele_ok_in ? bdcm_pkg::BDCM_WD_OK : state_reg;
      bdcm_pkg::BDCM_WD_OK:   state_next = tele_ok_in ? state_reg :
                                           (expired ? bdcm_pkg::BDCM_WD_LOST : state_reg);
      bdcm_pkg::BDCM_WD_LOST: state_next = tele_ok_in ? bdcm_pkg::BDCM_WD_OK : state_reg;
      default:                state_next = bdcm_pkg::BDCM_WD_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      tick_reg  <= 25'h0000000;
      sec_reg   <= 7'h00;
      state_reg <= bdcm_pkg::BDCM_WD_IDLE;
      lost_out  <= 1'b0;
    end else begin
      state_reg <= state_next;
      lost_out  <= (state_next == bdcm_pkg::BDCM_WD_LOST);
      if (tele_ok_in || state_reg != bdcm_pkg::BDCM_WD_OK) begin
        tick_reg <= 25'h0000000;
        sec_reg  <= 7'h00;
      end else if (sec_end) begin
        tick_reg <= 25'h0000000;
        sec_reg  <= sec_reg + 7'h01;
      end else begin
        tick_reg <= tick_reg + 25'h0000001;
      end
    end
  end
endmodule // bdcm_watchdog
`default_nettype wire

// [tb/bdcm_far_model.sv]
/* Fieldbus master model: sends decoded control words as telegrams.
   Assumes gap_in cycles between telegrams; 0 stops the link. */
`timescale 1ns/1ns
`default_nettype none
module bdcm_far_model (
  // Clock, reset and telegram spacing
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic [7:0] gap_in,
  // Decoded control word
  output logic            tele_ok_out,
  output logic            ser_rev_out,
  output logic [1:0]      ser_setup_out,
  output logic [1:0]      ser_preset_out,
  output logic            ser_jog_one_out,
  output logic            ser_jog_two_out
);
  int cnt;           // Cycles since last telegram
  int seed = 31684;  // Word generator seed
  initial {tele_ok_out, ser_rev_out, ser_setup_out, ser_preset_out} = 6'h00;
  initial {ser_jog_one_out, ser_jog_two_out} = 2'h0;
  always @(posedge core_clk_in) begin
    tele_ok_out <= 1'b0;
    if (!reset_n_in || gap_in == 8'h00) cnt <= 0;
    else if (cnt >= int'(gap_in) - 1) begin
      cnt <= 0;
      tele_ok_out <= 1'b1;
      {ser_rev_out, ser_setup_out, ser_preset_out, ser_jog_one_out, ser_jog_two_out}
        <= 7'($random(seed));
    end else cnt <= cnt + 1;
  end
endmodule // bdcm_far_model
`default_nettype wire

// [tb/bdcm_monitor.sv]
/* Port-level checker for bdcm_top.
   Assumes it is bound to bdcm_top and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module bdcm_monitor #(
  parameter int SEC_CYCLES = 50
) (
  // Clock and reset
  input wire logic        core_clk_in, reset_n_in,
  // Terminal and fieldbus inputs
  input wire logic        dig_rev_in, ser_rev_in, tele_ok_in, ser_jog_one_in, ser_jog_two_in,
  input wire logic [1:0]  dig_setup_in, ser_setup_in, dig_preset_in, ser_preset_in,
  // Merged outputs
  input wire logic        reverse_out, jog_active_out, bus_lost_out, relay_release_out,
  input wire logic [2:0]  setup_num_out, loss_action_out,
  input wire logic [1:0]  preset_sel_out,
  input wire logic [15:0] jog_freq_out
);
  int gap_cnt;  // Cycles since the last telegram
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////////
  // Gap counter, restarted by each telegram
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || tele_ok_in) gap_cnt <= 0;
    else gap_cnt <= gap_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////
  property p_rev_sub; reverse_out |-> $past(dig_rev_in | ser_rev_in); endproperty
  a_rev_sub: assert property (p_rev_sub) else $error("reverse without a source");
  property p_setup_sub;
    ((setup_num_out - 3'h1) & ~{1'b0, $past(dig_setup_in | ser_setup_in)}) == 3'h0;
  endproperty
  a_setup_sub: assert property (p_setup_sub) else $error("setup bit without a source");
  property p_preset_sub;
    (preset_sel_out & ~$past(dig_preset_in | ser_preset_in)) == 2'h0;
  endproperty
  a_preset_sub: assert property (p_preset_sub) else $error("preset bit without source");
  property p_jog_zero; !jog_active_out |-> jog_freq_out == 16'h0000; endproperty
  a_jog_zero: assert property (p_jog_zero) else $error("jog speed while idle");
  property p_jog_src; $rose(jog_active_out) |-> $past(ser_jog_one_in | ser_jog_two_in); endproperty
  a_jog_src: assert property (p_jog_src) else $error("jog without serial select");
  property p_lost_gap; $rose(bus_lost_out) |-> gap_cnt >= SEC_CYCLES; endproperty
  a_lost_gap: assert property (p_lost_gap) else $error("link lost too early");
  property p_tele_clear; tele_ok_in && bus_lost_out |-> ##[1:3] !bus_lost_out; endproperty
  a_tele_clear: assert property (p_tele_clear) else $error("telegram kept link lost");
  property p_act_idle; !bus_lost_out |-> loss_action_out == 3'h0; endproperty
  a_act_idle: assert property (p_act_idle) else $error("reaction while link ok");
  property p_relay; relay_release_out == (bus_lost_out && loss_action_out != 3'h0); endproperty
  a_relay: assert property (p_relay) else $error("relay release mismatch");
endmodule // bdcm_monitor
bind bdcm_top bdcm_monitor #(.SEC_CYCLES(SEC_CYCLES)) bdcm_monitor_i (
  .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .dig_rev_in(dig_rev_in),
  .ser_rev_in(ser_rev_in), .tele_ok_in(tele_ok_in), .ser_jog_one_in(ser_jog_one_in),
  .ser_jog_two_in(ser_jog_two_in), .dig_setup_in(dig_setup_in), .ser_setup_in(ser_setup_in),
  .dig_preset_in(dig_preset_in), .ser_preset_in(ser_preset_in), .reverse_out(reverse_out),
  .jog_active_out(jog_active_out), .bus_lost_out(bus_lost_out),
  .relay_release_out(relay_release_out), .setup_num_out(setup_num_out),
  .loss_action_out(loss_action_out), .preset_sel_out(preset_sel_out),
  .jog_freq_out(jog_freq_out));
`default_nettype wire

// [tb/bdcm_top_tb_top.sv]
/* Self-checking bench for bdcm_top with APB master and fieldbus model.
   Assumes SEC_CYCLES of 50 stands for one second. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module bdcm_top_tb_top;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, rnd_on = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, dig_rev = 0, tele_ok, ser_rev, jog1b, jog2b;
  logic [1:0]  dig_setup = 0, dig_preset = 0, ser_setup, ser_preset, preset, prof_o;
  logic        rev, jog_act, lost, relay, irq;
  logic [2:0]  setup, act;
  logic [15:0] jog_f, j1 = 16'h01F4, j2 = 16'h0FA0;
  logic [7:0]  gap = 8'h00;
  logic [1:0]  mr, ms, mp, prof;  // Shadow of mode fields and profile
  logic [33:0] q[$], e;           // Notes: read flag, error, data
  int          n_errors = 0, total_checks = 0, seed = 31684, cnt, i;
  logic [11:0] ra [8] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h024};
  logic [31:0] rv [8] = '{32'h3F, 32'h0, 32'h64, 32'h64, 32'h1, 32'h0, 32'hFA0, 32'h0};
  bdcm_top #(.SEC_CYCLES(50)) bdcm_top_i (.core_clk_in(clk), .reset_n_in(rst_n),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .dig_rev_in(dig_rev), .dig_setup_in(dig_setup), .dig_preset_in(dig_preset),
    .tele_ok_in(tele_ok), .ser_rev_in(ser_rev), .ser_setup_in(ser_setup),
    .ser_preset_in(ser_preset), .ser_jog_one_in(jog1b), .ser_jog_two_in(jog2b),
    .reverse_out(rev), .setup_num_out(setup), .preset_sel_out(preset),
    .jog_active_out(jog_act), .jog_freq_out(jog_f), .profile_out(prof_o),
    .bus_lost_out(lost), .loss_action_out(act), .relay_release_out(relay), .irq_out(irq));
  bdcm_far_model bdcm_far_model_i (.core_clk_in(clk), .reset_n_in(rst_n), .gap_in(gap),
    .tele_ok_out(tele_ok), .ser_rev_out(ser_rev), .ser_setup_out(ser_setup),
    .ser_preset_out(ser_preset), .ser_jog_one_out(jog1b), .ser_jog_two_out(jog2b));
  initial forever #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  // Verdict and run end
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Four-way source merge
  function automatic logic [1:0] mg(logic [1:0] m, logic [1:0] d, logic [1:0] s);
    return m == 2'h0 ? d : m == 2'h1 ? s : m == 2'h2 ? (d & s) : (d | s);
  endfunction
  // One APB transfer; the note goes to the queue
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic er);
    int k;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= w ? d : 32'h0;
    q.push_back({~w, er, w ? 32'h0 : d});
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin n_errors++; give_verdict; end
    psel <= 0; penable <= 0;
  endtask
  // Watcher takes the oldest note at each answer
  always @(posedge clk) if (psel && penable && pready === 1'b1) begin
    e = q.pop_front();
    `CHK("pslverr", e[32], pslverr)
    if (e[33]) `CHK("prdata", e[31:0], prdata)
  end
  // Random terminal levels
  always @(posedge clk) if (rnd_on) {dig_rev, dig_setup, dig_preset} <= 5'($random(seed));
  // Merge check: inputs before an edge, outputs after it
  task chk_cmd;
    logic [1:0] r, s, p;
    logic [15:0] jf;
    @(negedge clk);
    r = mg(mr, {1'b0, dig_rev}, {1'b0, ser_rev});
    s = mg(ms, dig_setup, ser_setup);
    p = (prof != 2'h1 && mp == 2'h2) ? dig_preset :
        mg(mp, dig_preset, prof == 2'h1 ? ser_preset : 2'h0);
    jf = prof != 2'h0 ? 16'h0 : jog1b ? j1 : jog2b ? j2 : 16'h0;
    @(negedge clk);
    `CHK("reverse", r[0], rev)
    `CHK("setup", {1'b0, s} + 3'h1, setup)
    `CHK("preset", p, preset)
    `CHK("jog_freq", jf, jog_f)
    `CHK("jog_act", jf != 16'h0, jog_act)
    `CHK("profile", prof, prof_o)
  endtask
  initial begin repeat (60000) @(posedge clk); n_errors++; give_verdict; end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    for (i = 0; i < 8; i++) apb(0, ra[i], rv[i], 0);
    apb(0, 12'h028, 0, 1);
    apb(1, 12'h028, 5, 1);
    apb(1, 12'h004, 3, 1);
    apb(1, 12'h010, 0, 1);
    apb(1, 12'h010, 100, 1);
    apb(1, 12'h014, 6, 1);
    apb(1, 12'h010, 99, 0);
    apb(0, 12'h010, 99, 0);
    apb(1, 12'h010, 1, 0);
    apb(0, 12'h004, 0, 0);
    apb(0, 12'h014, 0, 0);
    apb(1, 12'h008, j1, 0);
    apb(1, 12'h00C, 32'h1388, 0);
    apb(0, 12'h00C, j2, 0);
    gap <= 7; rnd_on <= 1;
    for (int pp = 0; pp < 3; pp++) for (int m = 0; m < 4; m++) begin
      prof = 2'(pp); mr = 2'(m); ms = 2'(m + 1); mp = 2'(m + 2);
      apb(1, 12'h004, prof, 0);
      apb(1, 12'h000, {mp, ms, mr}, 0);
      repeat (6) chk_cmd;
    end
    rnd_on <= 0;
    apb(1, 12'h010, 2, 0);
    apb(1, 12'h014, 3, 0);
    apb(1, 12'h024, 1, 0);
    i = 0;
    do begin @(negedge clk); i++; end while (tele_ok !== 1'b1 && i < 20);
    if (i >= 20) n_errors++;
    @(posedge clk) gap <= 0;
    cnt = 0; i = 0;
    while (lost !== 1'b1 && i < 400) begin @(negedge clk); i++; cnt = tele_ok ? 0 : cnt + 1; end
    `CHK("lost_time", 1'b1, cnt >= 101 && cnt <= 106)
    repeat (3) @(negedge clk);
    `CHK("irq_lost", 1'b1, irq)
    for (i = 0; i < 6; i++) begin
      apb(1, 12'h014, i, 0);
      repeat (2) @(negedge clk);
      `CHK("action", 3'(i), act)
      `CHK("relay", i != 0, relay)
    end
    apb(0, 12'h01C, 6, 0);
    apb(0, 12'h020, 1, 0);
    apb(1, 12'h020, 1, 0);
    apb(0, 12'h020, 0, 0);
    repeat (2) @(negedge clk);
    `CHK("irq_clr", 1'b0, irq)
    gap <= 9; i = 0;
    while (lost !== 1'b0 && i < 40) begin @(negedge clk); i++; end
    `CHK("regained", 1'b0, lost)
    apb(0, 12'h020, 2, 0);
    `CHK("irq_mask", 1'b0, irq)
    apb(1, 12'h024, 3, 0);
    repeat (3) @(negedge clk);
    `CHK("irq_unmask", 1'b1, irq)
    give_verdict;
  end
endmodule // bdcm_top_tb_top
`default_nettype wire
